/* ddsll_pkg.sv */
// Purpose: shared constants for the dual converter serial load logic
// Assumes: 12-bit code, pins sampled by a 200 MHz system clock
// Notes:   pin indices address the synchronised pin vector
package ddsll_pkg;

  // ----------------------------------------
  // code and preset values
  // ----------------------------------------
  localparam int          CODE_W      = 12;
  localparam logic [11:0] PRESET_HALF = 12'h800;
  localparam logic [11:0] PRESET_ZERO = 12'h000;
  localparam logic [11:0] CODE_RST    = 12'h000;

  // ----------------------------------------
  // synchronised pin vector layout
  // ----------------------------------------
  localparam int          N_PINS      = 8;
  localparam int          PIN_SCLK    = 0;
  localparam int          PIN_SDATA   = 1;
  localparam int          PIN_SEL_N   = 2;
  localparam int          PIN_CMT_A_N = 3;
  localparam int          PIN_CMT_B_N = 4;
  localparam int          PIN_PRE_N   = 5;
  localparam int          PIN_PRE_HI  = 6;
  localparam int          PIN_PWR_N   = 7;
  // active-low pins rest high after reset so nothing fires spuriously
  localparam logic [7:0]  SYNC_RST    = 8'hbc;

endpackage : ddsll_pkg

/* ddsll_pins_if.sv */
// Purpose: carries synchronised pin levels from the sampler to the core
// Assumes: one clock domain
// Notes:   levels only, no events
`timescale 1ns/1ps
`default_nettype none
interface ddsll_pins_if;
  import ddsll_pkg::*;
  logic [N_PINS-1:0] level;
  modport drive (output level);
  modport take  (input level);
endinterface : ddsll_pins_if
`default_nettype wire

/* ddsll_sync.sv */
// Purpose: two-flop synchroniser bank for all asynchronous pins
// Assumes: pins are stable levels between their own transitions
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module ddsll_sync
  import ddsll_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        clk_en,
  input  wire logic [ddsll_pkg::N_PINS-1:0] pins,
  ddsll_pins_if.drive                      out
);

  logic [N_PINS-1:0] stage1;
  logic [N_PINS-1:0] stage2;

  // ----------------------------------------
  // per-pin two-flop chain
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_PINS; g++)
    begin : g_pin
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          stage1[g] <= SYNC_RST[g];
          stage2[g] <= SYNC_RST[g];
        end
        else if (clk_en)
        begin
          stage1[g] <= pins[g];
          stage2[g] <= stage1[g];
        end
      end
    end
  endgenerate

  assign out.level = stage2;

endmodule : ddsll_sync
`default_nettype wire

/* ddsll_core.sv */
// Purpose: serial shift register and two level-sensitive converter code registers
// Assumes: host keeps serial clock period well above four system clocks (bench: 48 ns)
// Notes:   all pins pass two flops; serial data and clock share the same delay
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - select high: serial clock edges are ignored, shift register holds.
// - select does not gate either commit strobe.
// - select low: each rising serial clock shifts one bit, MSB first.
// - serial data bit enters shift register directly on each qualifying edge.
// - commit A low: code register A follows the shift register, level sensitive.
// - commit B low: code register B follows the shift register, level sensitive.
// - preset low forces both code registers, independent of serial clock.
// - preset with level select high gives half scale 800.
// - preset with level select low gives all zeros.
// - power-down keeps shift and code registers intact.
// - power-down still allows shifting and commits as normal.
// - leaving power-down, outputs show latest committed codes.
// - one shared 12-bit shift register, two 12-bit code registers.
// - extra clocks keep only the last twelve bits received.
// - strobe falling with select high updates register, then stays transparent.
module ddsll_core
  import ddsll_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        clk_en,
  input  wire logic                        serial_clk,
  input  wire logic                        serial_in,
  input  wire logic                        select_n,
  input  wire logic                        commit_a_n,
  input  wire logic                        commit_b_n,
  input  wire logic                        code_preset_n,
  input  wire logic                        preset_half,
  input  wire logic                        power_down_n,
  output var  logic [ddsll_pkg::CODE_W-1:0] output_a,
  output var  logic [ddsll_pkg::CODE_W-1:0] output_b,
  output var  logic [ddsll_pkg::CODE_W-1:0] shift_image,
  output var  logic                        outputs_active
);

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  ddsll_pins_if pins_sync ();

  ddsll_sync u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .pins    ({power_down_n, preset_half, code_preset_n, commit_b_n,
               commit_a_n, select_n, serial_in, serial_clk}),
    .out     (pins_sync)
  );

  logic              sclk_s;
  logic              sdata_s;
  logic              sel_n_s;
  logic              cmt_a_n_s;
  logic              cmt_b_n_s;
  logic              pre_n_s;
  logic              pre_hi_s;
  logic              pwr_n_s;
  logic              sclk_prev;
  logic              shift_edge;
  logic [CODE_W-1:0] shift_reg;
  logic [CODE_W-1:0] code_a;
  logic [CODE_W-1:0] code_b;
  logic [CODE_W-1:0] preset_code;

  assign sclk_s    = pins_sync.level[PIN_SCLK];
  assign sdata_s   = pins_sync.level[PIN_SDATA];
  assign sel_n_s   = pins_sync.level[PIN_SEL_N];
  assign cmt_a_n_s = pins_sync.level[PIN_CMT_A_N];
  assign cmt_b_n_s = pins_sync.level[PIN_CMT_B_N];
  assign pre_n_s   = pins_sync.level[PIN_PRE_N];
  assign pre_hi_s  = pins_sync.level[PIN_PRE_HI];
  assign pwr_n_s   = pins_sync.level[PIN_PWR_N];

  // ----------------------------------------
  // serial shift register
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      sclk_prev <= 1'b0;
    else if (clk_en)
      sclk_prev <= sclk_s;
  end

  assign shift_edge = sclk_s && !sclk_prev && !sel_n_s;

  // power-down not consulted here, so contents are kept
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      shift_reg <= CODE_RST;
    else if (clk_en && shift_edge)
    begin
      shift_reg <= {shift_reg[CODE_W-2:0], sdata_s};
    end
  end

  // ----------------------------------------
  // code registers
  // ----------------------------------------
  // half-scale or all-zeros preset
  function automatic logic [CODE_W-1:0] preset_value(input logic half);
    preset_value = half ? PRESET_HALF : PRESET_ZERO;
  endfunction : preset_value

  assign preset_code = preset_value(pre_hi_s);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      code_a <= CODE_RST;
    else if (clk_en)
    begin
      if (!pre_n_s)
        code_a <= preset_code;
      else if (!cmt_a_n_s)
        code_a <= shift_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      code_b <= CODE_RST;
    else if (clk_en)
    begin
      if (!pre_n_s)
        code_b <= preset_code;
      else if (!cmt_b_n_s)
        code_b <= shift_reg;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // outputs always track the code registers; power-down only flags them
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      output_a       <= CODE_RST;
      output_b       <= CODE_RST;
      shift_image    <= CODE_RST;
      outputs_active <= 1'b0;
    end
    else if (clk_en)
    begin
      output_a       <= code_a;
      output_b       <= code_b;
      shift_image    <= shift_reg;
      outputs_active <= pwr_n_s;
    end
  end

endmodule : ddsll_core
`default_nettype wire

/* ddsll_asserts.sv */
// Purpose: port checks of the serial load logic
// Assumes: clk_en high. Notes: pin to output lag is four edges, three for outputs_active
`timescale 1ns/1ps
`default_nettype none
module ddsll_asserts (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        select_n,
  input wire logic        commit_a_n,
  input wire logic        commit_b_n,
  input wire logic        code_preset_n,
  input wire logic        preset_half,
  input wire logic        power_down_n,
  input wire logic [11:0] output_a,
  input wire logic [11:0] output_b,
  input wire logic [11:0] shift_image,
  input wire logic        outputs_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_cs; select_n [*4] |=> $stable(shift_image); endproperty
  a_cs: assert property (p_cs) else $error("cs");
  property p_la; (!commit_a_n && code_preset_n)[*5] |=> output_a == $past(shift_image); endproperty
  a_la: assert property (p_la) else $error("la");
  property p_lb; (!commit_b_n && code_preset_n)[*5] |=> output_b == $past(shift_image); endproperty
  a_lb: assert property (p_lb) else $error("lb");
  property p_ph; (!code_preset_n && preset_half) [*4] |=> output_a == 12'h800; endproperty
  a_ph: assert property (p_ph) else $error("ph");
  property p_pz; (!code_preset_n && !preset_half) [*4] |=> output_b == 12'h000; endproperty
  a_pz: assert property (p_pz) else $error("pz");
  property p_ha; (commit_a_n && code_preset_n) [*4] |=> $stable(output_a); endproperty
  a_ha: assert property (p_ha) else $error("ha");
  property p_hb; (commit_b_n && code_preset_n) [*4] |=> $stable(output_b); endproperty
  a_hb: assert property (p_hb) else $error("hb");
  property p_pd; !$past(sys_rst, 4) |-> outputs_active == $past(power_down_n, 3); endproperty
  a_pd: assert property (p_pd) else $error("pd");
endmodule : ddsll_asserts
`default_nettype wire

/* ddsll_host.sv */
// Purpose: host model driving the serial pins
// Assumes: 48 ns serial clock. Notes: clock rests low between frames
`timescale 1ns/1ps
`default_nettype none
module ddsll_host (
  output var logic serial_clk = 1'b0,
  output var logic serial_in  = 1'b0,
  output var logic select_n   = 1'b1
);
  task automatic send(input logic [15:0] w, input logic sel_n);
    select_n <= sel_n;
    for (int i = 15; i >= 0; i--)
    begin
      serial_in <= w[i];
      #24 serial_clk <= 1'b1;
      #24 serial_clk <= 1'b0;
    end
    // released data line shows no stale bit
    #25 {select_n, serial_in} <= {1'b1, ~serial_in};
    // idle gap so a following frame never re-drives a pin in the same step
    #23;
  endtask : send
endmodule : ddsll_host
`default_nettype wire

/* dual_dac_serial_load_logic_test.sv */
// Purpose: directed test of the load logic
// Assumes: clk_en high outside the freeze test. Notes: pins() waits out the lag
`timescale 1ns/1ps
`default_nettype none
module dual_dac_serial_load_logic_test;
  logic        clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, preset_half = 1'b0;
  logic        commit_a_n = 1'b1, commit_b_n = 1'b1, code_preset_n = 1'b1, power_down_n = 1'b1;
  logic        serial_clk, serial_in, select_n, outputs_active;
  logic [11:0] output_a, output_b, shift_image;
  int          fail_count = 0, check_count = 0, cycles = 0;
  always #2.5 clk = ~clk;
  ddsll_core ddsll_core_inst (.*);
  ddsll_host host (.*);
  task automatic check(input string nm, input logic [11:0] seen, exp);
    check_count++;
    if (seen !== exp)
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    fail_count += int'(seen !== exp);
  endtask : check
  task automatic pins(input logic [4:0] v);
    @(posedge clk);
    {commit_a_n, commit_b_n, code_preset_n, preset_half, power_down_n} <= v;
    #31;
  endtask : pins
  task automatic conclude(input int extra);
    fail_count += extra;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  always @(posedge clk)
    if (++cycles == 1500)
      conclude(1);
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    pins(5'b11101);
    host.send(16'hfabc, 1'b0);
    check("s", shift_image, 12'habc);
    host.send(16'h0123, 1'b1);
    check("s", shift_image, 12'habc);
    $display("test shift end");
    pins(5'b01101);
    pins(5'b11101);
    check("a", output_a, 12'habc);
    pins(5'b00011);
    check("b", output_b, 12'h800);
    check("a", output_a, 12'h800);
    pins(5'b00001);
    check("a", output_a, 12'h000);
    pins(5'b11101);
    $display("test load end");
    // frozen core must not take a frame
    @(posedge clk);
    clk_en <= 1'b0;
    host.send(16'h0123, 1'b0);
    check("s", shift_image, 12'habc);
    @(posedge clk);
    clk_en <= 1'b1;
    $display("test freeze end");
    pins(5'b11100);
    check("s", shift_image, 12'habc);
    host.send(16'h05a5, 1'b0);
    pins(5'b10100);
    check("b", output_b, 12'h5a5);
    pins(5'b11101);
    check("act", 12'(outputs_active), 12'h001);
    check("b", output_b, 12'h5a5);
    pins(5'b00101);
    check("a", output_a, 12'h5a5);
    check("b", output_b, 12'h5a5);
    pins(5'b11101);
    $display("test power end");
    conclude(0);
  end
endmodule : dual_dac_serial_load_logic_test
bind ddsll_core ddsll_asserts ddsll_asserts_inst (.*);
`default_nettype wire
